/* testbench.sv */
// Self-checking testbench for the timer option block
`timescale 1ns/1ns
module testbench;
  import tor_pkg::*;
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] c;
  logic [4:1] ch = 4'hF;
  logic hreadyout;
  logic hresp;
  logic trigger;
  logic et;
  tor_trig_in_t trig_in;
  tor_pins_t pins;
  tor_pins_t ep;
  int n_fail = 0;
  int num_checks = 0;
  always #4 ref_clk = ~ref_clk;
  tor_top tor_top_i (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ch_out(ch), .trig_in(trig_in),
    .pins(pins), .trigger(trigger));
  tor_src_model tor_src_model_i (.ref_clk(ref_clk), .trig_in(trig_in));
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task hwait;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'h1) begin
      n++;
      if (n > 20) begin
        n_fail++;
        stop_test();
      end
      @(posedge ref_clk);
    end
  endtask : hwait
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= TOR_HTRANS_NONSEQ;
    hwrite <= w;
    hwait();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    rd = hrdata;
    chk("hresp", hresp, 32'h0);
    chk("hready", hreadyout, 32'h1);
  endtask : xfer
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'h0;
    xfer(1'h0, TOR_OPT_OFFSET, 32'h0);
    chk("reset value", rd, TOR_OPT_RESET);
    chk("reset pins", pins, 8'hF0);
    for (int i = 0; i < 128; i++) begin
      // Reserved bit 3 and bits 31:8 stay zero
      c = {24'h0, i[6:3], 1'h0, i[2:0]};
      xfer(1'h1, TOR_OPT_OFFSET, c);
      xfer(1'h0, TOR_OPT_OFFSET, 32'h0);
      chk("readback", rd, c);
      ch <= i[3:0] ^ 4'hA;
      repeat (4) begin
        @(negedge ref_clk);
        ep.port_a = {ch[2] & ~c[5], ch[4] & ~c[7], ch[3] & ~c[6], ch[1] & ~c[4]};
        ep.port_b = {ch[4] & c[7], ch[3] & c[6], ch[2] & c[5], ch[1] & c[4]};
        et = (c[1:0] == TOR_TRIG_PCLK) ? trig_in.pclk_tick :
          (c[1:0] == TOR_TRIG_1K) ? trig_in.cal_1k_tick :
          (c[1:0] == TOR_TRIG_32K) ? trig_in.ref_32k_tick :
          trig_in.ext_pin & (trig_in.mask_in | ~c[2]);
        chk("pins", pins, ep);
        chk("trigger", trigger, et);
      end
      @(posedge ref_clk);
    end
    xfer(1'h1, TOR_OPT_OFFSET, 32'hFFFFFFFF);
    xfer(1'h0, TOR_OPT_OFFSET, 32'h0);
    chk("reserved bits", rd, TOR_OPT_WMASK);
    xfer(1'h0, 32'h0000F054, 32'h0);
    chk("unmapped read", rd, 32'h0);
    xfer(1'h1, 32'h0001F050, 32'h0);
    xfer(1'h0, TOR_OPT_OFFSET, 32'h0);
    chk("unmapped write", rd, TOR_OPT_WMASK);
    reset <= 1'h1;
    @(posedge ref_clk);
    reset <= 1'h0;
    xfer(1'h0, TOR_OPT_OFFSET, 32'h0);
    chk("second reset", rd, TOR_OPT_RESET);
    stop_test();
  end
endmodule : testbench

/* tor_pkg.sv */
// Package with register map, field layout and carrier types for the timer option block
package tor_pkg;
  localparam logic [15:0] TOR_OPT_OFFSET = 16'hF050;
  localparam logic [31:0] TOR_OPT_RESET = 32'h00000000;
  localparam logic [31:0] TOR_OPT_WMASK = 32'h000000F7;
  localparam int TOR_SEL_LSB = 0;
  localparam int TOR_MSK_BIT = 2;
  localparam int TOR_RSVD_BIT = 3;
  localparam int TOR_CH1_BIT = 4;
  localparam int TOR_CH2_BIT = 5;
  localparam int TOR_CH3_BIT = 6;
  localparam int TOR_CH4_BIT = 7;
  localparam logic [1:0] TOR_TRIG_PCLK = 2'h0;
  localparam logic [1:0] TOR_TRIG_1K = 2'h1;
  localparam logic [1:0] TOR_TRIG_32K = 2'h2;
  localparam logic [1:0] TOR_TRIG_PIN = 2'h3;
  localparam logic [1:0] TOR_HTRANS_NONSEQ = 2'h2;
  localparam int TOR_ADDR_W = 16;

  typedef struct packed {
    logic [3:0] ch_alt;
    logic clk_mask_en;
    logic [1:0] trig_sel;
  } tor_cfg_t;

  typedef struct packed {
    logic [3:0] port_a;
    logic [4:1] port_b;
  } tor_pins_t;

  typedef struct packed {
    logic pclk_tick;
    logic cal_1k_tick;
    logic ref_32k_tick;
    logic ext_pin;
    logic mask_in;
  } tor_trig_in_t;
endpackage : tor_pkg

/* tor_route.sv */
// Channel to pin router and trigger source selector
`timescale 1ns/1ns
module tor_route
  import tor_pkg::*;
(
  input wire tor_pkg::tor_cfg_t cfg,
  input wire logic [4:1] ch_out,
  input wire tor_pkg::tor_trig_in_t trig_in,
  output tor_pkg::tor_pins_t pins,
  output logic trigger
);
  always_comb begin
    pins = '0;
    pins.port_a[2] = ch_out[4] & ~cfg.ch_alt[3];
    pins.port_b[4] = ch_out[4] & cfg.ch_alt[3];
    pins.port_a[1] = ch_out[3] & ~cfg.ch_alt[2];
    pins.port_b[3] = ch_out[3] & cfg.ch_alt[2];
    pins.port_a[3] = ch_out[2] & ~cfg.ch_alt[1];
    pins.port_b[2] = ch_out[2] & cfg.ch_alt[1];
    pins.port_a[0] = ch_out[1] & ~cfg.ch_alt[0];
    pins.port_b[1] = ch_out[1] & cfg.ch_alt[0];
  end

  always_comb begin
    case (cfg.trig_sel)
      TOR_TRIG_PCLK: trigger = trig_in.pclk_tick;
      TOR_TRIG_1K: trigger = trig_in.cal_1k_tick;
      TOR_TRIG_32K: trigger = trig_in.ref_32k_tick;
      TOR_TRIG_PIN: trigger = cfg.clk_mask_en ? (trig_in.ext_pin & trig_in.mask_in)
                                               : trig_in.ext_pin;
      default: trigger = 1'b0;
    endcase
  end
endmodule : tor_route

/* tor_src_model.sv */
// Model of the trigger clock sources and clock mask pin
`timescale 1ns/1ns
module tor_src_model
  import tor_pkg::*;
(
  input wire logic ref_clk,
  output tor_pkg::tor_trig_in_t trig_in
);
  import tor_pkg::*;
  logic [4:0] cnt = 5'h00;
  // Every source level combination appears within 32 cycles
  always @(posedge ref_clk) begin
    cnt <= cnt + 5'h01;
  end
  assign trig_in = cnt;
endmodule : tor_src_model

/* tor_top.sv */
// Timer option register with AHB-Lite slave, pin routing and trigger select
//
// Summary of operation
// - Channel 4 goes to port A bit 2, or port B bit 4 when bit 7 set.
// - Channel 3 goes to port A bit 1, or port B bit 3 when bit 6 set.
// - Channel 2 goes to port A bit 3, or port B bit 2 when bit 5 set.
// - Channel 1 goes to port A bit 0, or port B bit 1 when bit 4 set.
// - Bit 2 set and pin trigger selected: pin clock ANDed with mask input.
// - Bits 1:0 pick trigger: peripheral, 1 kHz, 32 kHz, or external pin.
// - Reset clears the option register to zero.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
module tor_top
  import tor_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [4:1] ch_out,
  input wire tor_pkg::tor_trig_in_t trig_in,
  output tor_pkg::tor_pins_t pins,
  output logic trigger
);
  logic [31:0] opt_reg;
  logic [31:0] next_opt_reg;
  logic wr_pend;
  logic next_wr_pend;
  logic [31:0] next_hrdata;
  tor_cfg_t cfg;

  function automatic logic hit(input logic [31:0] a);
    hit = (a[TOR_ADDR_W-1:0] == TOR_OPT_OFFSET) && (a[31:TOR_ADDR_W] == '0);
  endfunction : hit

  wire logic take = hsel && hready && (htrans == TOR_HTRANS_NONSEQ);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    next_wr_pend = take && hwrite && hit(haddr);
    next_opt_reg = opt_reg;
    if (wr_pend) begin
      next_opt_reg = hwdata & TOR_OPT_WMASK;
    end
    next_hrdata = hrdata;
    if (take && !hwrite) begin
      next_hrdata = hit(haddr) ? (opt_reg & TOR_OPT_WMASK) : 32'h00000000;
      if (wr_pend && hit(haddr)) begin
        next_hrdata = hwdata & TOR_OPT_WMASK;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      opt_reg <= TOR_OPT_RESET;
      wr_pend <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      opt_reg <= next_opt_reg;
      wr_pend <= next_wr_pend;
      hrdata <= next_hrdata;
    end
  end

  assign cfg.ch_alt = opt_reg[TOR_CH4_BIT:TOR_CH1_BIT];
  assign cfg.clk_mask_en = opt_reg[TOR_MSK_BIT];
  assign cfg.trig_sel = opt_reg[TOR_SEL_LSB+1:TOR_SEL_LSB];

  tor_route u_route (
    .cfg(cfg),
    .ch_out(ch_out),
    .trig_in(trig_in),
    .pins(pins),
    .trigger(trigger)
  );

  sequence wr_addr_s;
    take && hwrite && hit(haddr);
  endsequence

  sequence wr_data_s;
    wr_addr_s ##1 1'b1;
  endsequence

  sequence rd_addr_s;
    take && !hwrite && hit(haddr);
  endsequence

  sequence miss_addr_s;
    take && !hit(haddr);
  endsequence

  reset_clears_a: assert property (@(posedge ref_clk)
    reset |=>
      (opt_reg == TOR_OPT_RESET))
    else $error("option register not cleared by reset");

  reset_read_a: assert property (@(posedge ref_clk)
    reset |=>
      (hrdata == 32'h00000000))
    else $error("read data not cleared by reset");

  reset_pend_a: assert property (@(posedge ref_clk)
    reset |=>
      !wr_pend)
    else $error("pending write survives reset");

  reset_pins_a: assert property (@(posedge ref_clk)
    reset |=>
      (pins.port_b == 4'h0))
    else $error("alternate pins driven after reset");

  reset_trigger_a: assert property (@(posedge ref_clk)
    reset |=>
      (trigger == trig_in.pclk_tick))
    else $error("trigger not peripheral clock after reset");

  hready_high_a: assert property (@(posedge ref_clk) disable iff (reset)
    take |->
      hreadyout)
    else $error("wait state inserted");

  okay_resp_a: assert property (@(posedge ref_clk) disable iff (reset)
    take |=>
      !hresp)
    else $error("error response given");

  write_word_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_data_s |=>
      (opt_reg == ($past(hwdata) & TOR_OPT_WMASK)))
    else $error("written word not stored through mask");

  write_lands_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_data_s |=>
      (opt_reg[7:0] == ($past(hwdata[7:0]) & 8'hF7)))
    else $error("write data not stored");

  sel_field_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_data_s |=>
      (opt_reg[TOR_SEL_LSB+1:TOR_SEL_LSB] == $past(hwdata[TOR_SEL_LSB+1:TOR_SEL_LSB])))
    else $error("trigger select field not stored");

  write_pend_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_addr_s |=>
      wr_pend)
    else $error("register write not taken");

  no_pend_a: assert property (@(posedge ref_clk) disable iff (reset)
    !(take && hwrite && hit(haddr)) |=>
      !wr_pend)
    else $error("write pending without request");

  miss_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    miss_addr_s ##0 hwrite |=>
      !wr_pend)
    else $error("unmapped write taken");

  opt_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !wr_pend |=>
      $stable(opt_reg))
    else $error("option register changed without write");

  read_data_a: assert property (@(posedge ref_clk) disable iff (reset)
    rd_addr_s ##0 !wr_pend |=>
      (hrdata == ($past(opt_reg) & TOR_OPT_WMASK)))
    else $error("register read data wrong");

  miss_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    miss_addr_s ##0 !hwrite |=>
      (hrdata == 32'h00000000))
    else $error("unmapped read not zero");

  read_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !(take && !hwrite) |=>
      $stable(hrdata))
    else $error("read data changed without read");

  read_clean_a: assert property (@(posedge ref_clk) disable iff (reset)
    rd_addr_s |=>
      ((hrdata[31:8] == 24'h000000) && !hrdata[TOR_RSVD_BIT]))
    else $error("reserved bits read nonzero");

  write_rsvd_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_data_s |=>
      !opt_reg[TOR_RSVD_BIT])
    else $error("reserved bit stored by write");

  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    (opt_reg[31:8] == '0) &&
      !opt_reg[TOR_RSVD_BIT])
    else $error("reserved option bits not zero");

  upper_kept_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_pend |=>
      (opt_reg[31:8] == '0))
    else $error("upper bits changed by write");

  ch4_route_a: assert property (@(posedge ref_clk) disable iff (reset)
    ch_out[4] |-> (opt_reg[TOR_CH4_BIT] ? pins.port_b[4] && !pins.port_a[2]
                                       : pins.port_a[2] && !pins.port_b[4]))
    else $error("channel 4 misrouted");

  ch3_route_a: assert property (@(posedge ref_clk) disable iff (reset)
    ch_out[3] |->
      (opt_reg[TOR_CH3_BIT] ? pins.port_b[3] : pins.port_a[1]))
    else $error("channel 3 misrouted");

  ch2_route_a: assert property (@(posedge ref_clk) disable iff (reset)
    ch_out[2] |->
      (opt_reg[TOR_CH2_BIT] ? pins.port_b[2] : pins.port_a[3]))
    else $error("channel 2 misrouted");

  ch1_route_a: assert property (@(posedge ref_clk) disable iff (reset)
    ch_out[1] |->
      (opt_reg[TOR_CH1_BIT] ? pins.port_b[1] : pins.port_a[0]))
    else $error("channel 1 misrouted");

  ch4_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    !ch_out[4] |->
      (!pins.port_a[2] && !pins.port_b[4]))
    else $error("channel 4 pins driven while idle");

  ch3_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    !ch_out[3] |->
      (!pins.port_a[1] && !pins.port_b[3]))
    else $error("channel 3 pins driven while idle");

  ch2_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    !ch_out[2] |->
      (!pins.port_a[3] && !pins.port_b[2]))
    else $error("channel 2 pins driven while idle");

  ch1_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
    !ch_out[1] |->
      (!pins.port_a[0] && !pins.port_b[1]))
    else $error("channel 1 pins driven while idle");

  ch3_excl_a: assert property (@(posedge ref_clk) disable iff (reset)
    opt_reg[TOR_CH3_BIT] |->
      !pins.port_a[1])
    else $error("channel 3 main pin driven while remapped");

  ch2_excl_a: assert property (@(posedge ref_clk) disable iff (reset)
    opt_reg[TOR_CH2_BIT] |->
      !pins.port_a[3])
    else $error("channel 2 main pin driven while remapped");

  ch1_excl_a: assert property (@(posedge ref_clk) disable iff (reset)
    opt_reg[TOR_CH1_BIT] |->
      !pins.port_a[0])
    else $error("channel 1 main pin driven while remapped");

  alt_none_a: assert property (@(posedge ref_clk) disable iff (reset)
    (opt_reg[TOR_CH4_BIT:TOR_CH1_BIT] == 4'h0) |->
      (pins.port_b == 4'h0))
    else $error("port B driven with no remap");

  alt_all_a: assert property (@(posedge ref_clk) disable iff (reset)
    (opt_reg[TOR_CH4_BIT:TOR_CH1_BIT] == 4'hF) |->
      (pins.port_a == 4'h0))
    else $error("port A driven with full remap");

  mask_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
    (cfg.trig_sel == TOR_TRIG_PIN) |->
      (trigger == (trig_in.ext_pin & (trig_in.mask_in | !cfg.clk_mask_en))))
    else $error("pin trigger mask wrong");

  trig_sel_a: assert property (@(posedge ref_clk) disable iff (reset)
    (cfg.trig_sel == TOR_TRIG_1K) |->
      (trigger == trig_in.cal_1k_tick))
    else $error("trigger source wrong");

  trig_pclk_a: assert property (@(posedge ref_clk) disable iff (reset)
    (opt_reg[TOR_SEL_LSB+1:TOR_SEL_LSB] == TOR_TRIG_PCLK) |->
      (trigger == trig_in.pclk_tick))
    else $error("peripheral clock trigger wrong");

  trig_ref_a: assert property (@(posedge ref_clk) disable iff (reset)
    (opt_reg[TOR_SEL_LSB+1:TOR_SEL_LSB] == TOR_TRIG_32K) |->
      (trigger == trig_in.ref_32k_tick))
    else $error("reference clock trigger wrong");

  mask_off_a: assert property (@(posedge ref_clk) disable iff (reset)
    ((opt_reg[TOR_SEL_LSB+1:TOR_SEL_LSB] == TOR_TRIG_PIN) && !opt_reg[TOR_MSK_BIT]) |->
      (trigger == trig_in.ext_pin))
    else $error("mask applied while disabled");

  mask_on_a: assert property (@(posedge ref_clk) disable iff (reset)
    ((opt_reg[TOR_SEL_LSB+1:TOR_SEL_LSB] == TOR_TRIG_PIN) && opt_reg[TOR_MSK_BIT]) |->
      (trigger == (trig_in.ext_pin & trig_in.mask_in)))
    else $error("mask not applied while enabled");
endmodule : tor_top
